//--- adcres_bank.sv
// Read-only bank of charge current, bus voltage and battery voltage results
`timescale 1ns/1ps
`include "adcres_params.svh"
module adcres_bank
  import adcres_pkg::*;
(
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst_b,
  // Software register reset, one cycle
  input  wire logic         i_reg_reset,
  // Channel disable bits, from the disable register
  input  wire logic         i_charge_current_conv_off,
  input  wire logic         i_bus_voltage_conv_off,
  input  wire logic         i_battery_voltage_conv_off,
  // Converter results, same clock domain
  input  wire logic         i_chg_valid,
  input  wire logic [14:0]  i_charge_current_result,
  input  wire logic         i_bus_valid,
  input  wire logic [15:0]  i_bus_voltage_result,
  input  wire logic         i_bat_valid,
  input  wire logic [15:0]  i_battery_voltage_result,
  // Register port from the serial bus engine
  input  wire logic         i_reg_rd,
  input  wire logic         i_reg_wr,
  input  wire logic [7:0]   i_reg_addr,
  input  wire logic [7:0]   i_reg_wdata,
  output adcres_byte_t      o_reg_rdata,
  output logic              o_reg_hit
);
  // Reset release through two flops
  logic rst_s1_ff;
  logic rst_b_ff;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_ff <= 1'b0;
      rst_b_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_b_ff  <= rst_s1_ff;
    end
  end

  // Read mux slices assume a 15-bit charge result; refuse anything else
  initial begin
    if (`ADCRES_CHG_W != 15) begin
      $error("adcres_bank charge result width must be 15");
    end
  end

  logic [14:0]  chg_q;
  adcres_word_t bus_q;
  adcres_word_t bat_q;

  // Holding registers, one per channel
  adcres_hold #(.WIDTH(`ADCRES_CHG_W)) u_chg (
    .i_clock    (i_clock),
    .i_rst_b    (rst_b_ff),
    .i_reg_reset(i_reg_reset),
    .i_conv_off (i_charge_current_conv_off),
    .i_valid    (i_chg_valid),
    .i_data     (i_charge_current_result),
    .o_data     (chg_q)
  );
  adcres_hold #(.WIDTH(16)) u_bus (
    .i_clock    (i_clock),
    .i_rst_b    (rst_b_ff),
    .i_reg_reset(i_reg_reset),
    .i_conv_off (i_bus_voltage_conv_off),
    .i_valid    (i_bus_valid),
    .i_data     (i_bus_voltage_result),
    .o_data     (bus_q)
  );
  // Low battery byte lives elsewhere; only the upper half is read here
  adcres_hold #(.WIDTH(16)) u_bat (
    .i_clock    (i_clock),
    .i_rst_b    (rst_b_ff),
    .i_reg_reset(i_reg_reset),
    .i_conv_off (i_battery_voltage_conv_off),
    .i_valid    (i_bat_valid),
    .i_data     (i_battery_voltage_result),
    .o_data     (bat_q)
  );

  // Result map seen by the host:
  //   charge high  : zero, charge bits 14..8
  //   charge low   : charge bits 7..0
  //   bus high     : bus bits 15..8, sign on top
  //   bus low      : bus bits 7..0
  //   battery high : battery bits 15..8, sign on top
  // Bytes are not latched together, so a host reading
  // high then low may straddle a refresh between them.
  // Every other offset reads zero with the hit flag low.

  // True for the five result offsets; shared by the read checks
  function automatic logic adcres_is_result(input adcres_byte_t a);
    adcres_is_result = (a >= `ADCRES_OFS_CHG_HI) && (a <= `ADCRES_OFS_BAT_HI);
  endfunction : adcres_is_result

  // Read mux; writes never reach the holding registers
  adcres_byte_t nxt_rdata;
  logic         nxt_hit;
  always_comb begin
    nxt_rdata = `ADCRES_UNMAPPED_VAL;
    nxt_hit   = 1'b1;
    unique case (i_reg_addr)
      `ADCRES_OFS_CHG_HI: nxt_rdata = {1'b0, chg_q[14:8]};
      `ADCRES_OFS_CHG_LO: nxt_rdata = chg_q[7:0];
      `ADCRES_OFS_BUS_HI: nxt_rdata = bus_q[15:8];
      `ADCRES_OFS_BUS_LO: nxt_rdata = bus_q[7:0];
      `ADCRES_OFS_BAT_HI: nxt_rdata = bat_q[15:8];
      default:            nxt_hit   = 1'b0;
    endcase
  end

  // Registered read data, held between reads
  always_ff @(posedge i_clock or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      o_reg_rdata <= 8'h00;
      o_reg_hit   <= 1'b0;
    end else if (i_reg_rd) begin
      o_reg_rdata <= nxt_rdata;
      o_reg_hit   <= nxt_hit;
    end
  end

  // Read data per offset
  chg_top_zero_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_reg_rd && i_reg_addr == `ADCRES_OFS_CHG_HI) |=> o_reg_rdata[7] == 1'b0)
    else $error("charge bit 7 set");

  chg_hi_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_reg_rd && i_reg_addr == `ADCRES_OFS_CHG_HI) |=> o_reg_rdata[6:0] == $past(chg_q[14:8]))
    else $error("charge high wrong");

  chg_lo_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_reg_rd && i_reg_addr == `ADCRES_OFS_CHG_LO) |=> o_reg_rdata == $past(chg_q[7:0]))
    else $error("charge low wrong");

  bus_hi_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_reg_rd && i_reg_addr == `ADCRES_OFS_BUS_HI) |=> o_reg_rdata == $past(bus_q[15:8]))
    else $error("bus high wrong");

  bus_sign_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_reg_rd && i_reg_addr == `ADCRES_OFS_BUS_HI) |=> o_reg_rdata[7] == $past(bus_q[15]))
    else $error("bus sign wrong");

  bus_lo_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_reg_rd && i_reg_addr == `ADCRES_OFS_BUS_LO) |=> o_reg_rdata == $past(bus_q[7:0]))
    else $error("bus low wrong");

  bat_hi_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_reg_rd && i_reg_addr == `ADCRES_OFS_BAT_HI) |=> o_reg_rdata == $past(bat_q[15:8]))
    else $error("battery high wrong");

  bat_sign_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_reg_rd && i_reg_addr == `ADCRES_OFS_BAT_HI) |=> o_reg_rdata[7] == $past(bat_q[15]))
    else $error("battery sign wrong");

  // Hit flag and unmapped reads
  hit_set_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_reg_rd && adcres_is_result(i_reg_addr)) |=> o_reg_hit)
    else $error("hit flag missing");

  hit_clear_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_reg_rd && !adcres_is_result(i_reg_addr)) |=> (!o_reg_hit && o_reg_rdata == 8'h00))
    else $error("unmapped read not zero");

  // Read answer stands until the next read
  rdata_hold_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    !i_reg_rd |=> ($stable(o_reg_rdata) && $stable(o_reg_hit)))
    else $error("read data moved");

  // Register reset clears every channel, even against a sample
  reg_clear_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    i_reg_reset |=> (chg_q == '0 && bus_q == '0 && bat_q == '0))
    else $error("register reset missed");

  out_reset_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    $rose(rst_b_ff) |-> (o_reg_rdata == 8'h00 && !o_reg_hit))
    else $error("read port not cleared");

  // Disabled channels keep their last result unless a register reset clears them
  chg_off_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_charge_current_conv_off && !i_reg_reset) |=> $stable(chg_q))
    else $error("charge refreshed while off");

  bus_off_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_bus_voltage_conv_off && !i_reg_reset) |=> $stable(bus_q))
    else $error("bus refreshed while off");

  bat_off_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_battery_voltage_conv_off && !i_reg_reset) |=> $stable(bat_q))
    else $error("battery refreshed while off");

  // Enabled channels take their sample at the next edge
  chg_land_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_chg_valid && !i_charge_current_conv_off && !i_reg_reset) |=> chg_q == $past(i_charge_current_result))
    else $error("charge sample lost");

  bus_land_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_bus_valid && !i_bus_voltage_conv_off && !i_reg_reset) |=> bus_q == $past(i_bus_voltage_result))
    else $error("bus sample lost");

  bat_land_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_bat_valid && !i_battery_voltage_conv_off && !i_reg_reset) |=> bat_q == $past(i_battery_voltage_result))
    else $error("battery sample lost");

  // Host writes leave results and read port alone
  write_ignored_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_reg_wr && !i_chg_valid && !i_reg_reset) |=> $stable(chg_q))
    else $error("write altered result");

  bus_write_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_reg_wr && !i_bus_valid && !i_reg_reset) |=> $stable(bus_q))
    else $error("write altered bus result");

  bat_write_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_reg_wr && !i_bat_valid && !i_reg_reset) |=> $stable(bat_q))
    else $error("write altered battery result");

  wr_no_out_a: assert property (@(posedge i_clock) disable iff (!rst_b_ff)
    (i_reg_wr && !i_reg_rd) |=> $stable(o_reg_rdata))
    else $error("write altered read data");

  // Reset release order of the two-flop stretcher
  sync_order_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !rst_s1_ff |=> !rst_b_ff)
    else $error("reset released early");
endmodule : adcres_bank

//--- adcres_hold.sv
// One result holding register with refresh gating and register-reset clear
`timescale 1ns/1ps
`include "adcres_params.svh"
module adcres_hold
  import adcres_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  // Control
  input  wire logic             i_reg_reset,
  input  wire logic             i_conv_off,
  // Sample from converter
  input  wire logic             i_valid,
  input  wire logic [WIDTH-1:0] i_data,
  // Held result
  output logic      [WIDTH-1:0] o_data
);
  initial begin
    if (WIDTH < 1 || WIDTH > 16) $error("adcres_hold WIDTH out of range");
  end

  logic [WIDTH-1:0] data_ff;

  // Watchdog expiry has no input here, so contents survive it
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      data_ff <= WIDTH'(`ADCRES_RESET_VAL);
    end else if (i_reg_reset) begin
      data_ff <= WIDTH'(`ADCRES_RESET_VAL);
    end else if (i_valid && !i_conv_off) begin
      data_ff <= i_data;
    end
  end
  assign o_data = data_ff;

  clear_wins_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_reg_reset |=> data_ff == '0) else $error("result not cleared");
  off_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_conv_off && !i_reg_reset) |=> $stable(data_ff)) else $error("disabled channel refreshed");
  refresh_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_valid && !i_conv_off && !i_reg_reset) |=> data_ff == $past(i_data)) else $error("result not refreshed");
endmodule : adcres_hold

//--- adcres_host.sv
// Host model driving the register read and write strobes
`timescale 1ns/1ps
module adcres_host (
  // Clock
  input  wire logic       i_clock,
  // Register port toward the bank
  output logic            o_rd,
  output logic            o_wr,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata
);
  // Idle strobes low, address parked off the map
  initial begin
    o_rd    = 1'b0;
    o_wr    = 1'b0;
    o_addr  = 8'hFF;
    o_wdata = 8'h00;
  end
  // One access held for exactly one taking edge
  task automatic access(input logic rd, input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_rd    <= rd;
    o_wr    <= wr;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_clock);
    o_rd    <= 1'b0;
    o_wr    <= 1'b0;
    o_addr  <= 8'hFF;
    o_wdata <= ~d;
  endtask : access
endmodule : adcres_host

//--- adcres_params.svh
// Offsets, field positions and reset values of the measurement result registers
`ifndef ADCRES_PARAMS_SVH
`define ADCRES_PARAMS_SVH
`define ADCRES_OFS_CHG_HI   8'h19
`define ADCRES_OFS_CHG_LO   8'h1A
`define ADCRES_OFS_BUS_HI   8'h1B
`define ADCRES_OFS_BUS_LO   8'h1C
`define ADCRES_OFS_BAT_HI   8'h1D
`define ADCRES_CHG_W        15
`define ADCRES_RESET_VAL    16'h0000
`define ADCRES_UNMAPPED_VAL 8'h00
`endif

//--- adcres_pkg.sv
// Types shared by the result register bank
package adcres_pkg;
  typedef logic [7:0]  adcres_byte_t;
  typedef logic [15:0] adcres_word_t;
endpackage : adcres_pkg

//--- tb.sv
// Self-checking bench for the result register bank
`timescale 1ns/1ps
module tb;
  import adcres_pkg::*;
  logic         i_clock, rst_b, reg_reset, off_c, off_v, off_b, vc, vv, vb, rd, wr, hit;
  logic [14:0]  chg;
  logic [15:0]  bus, bat;
  logic [7:0]   addr, wdata;
  adcres_byte_t rdata;
  int           miscompares, checks_done, i;
  // Rows: address, expected byte, expected hit
  adcres_byte_t row_a [6] = '{8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E};
  adcres_byte_t row_d [6] = '{8'h7F, 8'hFF, 8'h80, 8'h01, 8'hC3, 8'h00};
  logic         row_h [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  adcres_bank dut_u (.i_clock(i_clock), .i_rst_b(rst_b), .i_reg_reset(reg_reset),
    .i_charge_current_conv_off(off_c), .i_bus_voltage_conv_off(off_v), .i_battery_voltage_conv_off(off_b),
    .i_chg_valid(vc), .i_charge_current_result(chg), .i_bus_valid(vv), .i_bus_voltage_result(bus),
    .i_bat_valid(vb), .i_battery_voltage_result(bat), .i_reg_rd(rd), .i_reg_wr(wr),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_hit(hit));
  adcres_host host_u (.i_clock(i_clock), .o_rd(rd), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
  // Free running 50 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  task automatic close_out();
    if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input adcres_byte_t got, input adcres_byte_t exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Read answer lands at the taking edge; checked at the falling edge after it
  task automatic rd_chk(input adcres_byte_t a, input adcres_byte_t d, input logic h);
    host_u.access(1'b1, 1'b0, a, 8'h00);
    @(negedge i_clock);
    chk("rdata", rdata, d);
    chk("hit", {7'h00, hit}, {7'h00, h});
  endtask : rd_chk
  // One converter sample on all three channels
  task automatic load(input logic [14:0] c, input logic [15:0] v, input logic [15:0] b);
    @(posedge i_clock);
    {vc, vv, vb, chg, bus, bat} <= {3'h7, c, v, b};
    @(posedge i_clock);
    {vc, vv, vb} <= 3'h0;
  endtask : load
  // Watchdog far beyond the expected run of under a hundred cycles
  initial begin
    #20us;
    miscompares++;
    close_out();
  end
  initial begin
    {rst_b, reg_reset, off_c, off_v, off_b, vc, vv, vb, chg, bus, bat} = '0;
    repeat (20) @(posedge i_clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge i_clock);
    for (i = 0; i < 6; i++) rd_chk(row_a[i], 8'h00, row_h[i]);
    load(15'h7FFF, 16'h8001, 16'hC3A5);
    for (i = 0; i < 6; i++) rd_chk(row_a[i], row_d[i], row_h[i]);
    host_u.access(1'b0, 1'b1, 8'h1A, 8'h55);
    rd_chk(8'h1A, 8'hFF, 1'b1);
    // Disabled channels must keep their last result until a register reset clears them
    @(posedge i_clock);
    {off_c, off_v, off_b} <= 3'h7;
    load(15'h0123, 16'h1234, 16'h5678);
    rd_chk(8'h1A, 8'hFF, 1'b1);
    rd_chk(8'h1C, 8'h01, 1'b1);
    rd_chk(8'h1D, 8'hC3, 1'b1);
    @(posedge i_clock);
    reg_reset <= 1'b1;
    @(posedge i_clock);
    reg_reset <= 1'b0;
    rd_chk(8'h1B, 8'h00, 1'b1);
    // Register reset and an enabled sample in one cycle: clear wins
    @(posedge i_clock);
    {off_c, off_v, off_b} <= 3'h0;
    reg_reset <= 1'b1;
    {vc, vv, vb, chg, bus, bat} <= {3'h7, 15'h0123, 16'h1234, 16'h5678};
    @(posedge i_clock);
    reg_reset <= 1'b0;
    {vc, vv, vb} <= 3'h0;
    rd_chk(8'h1C, 8'h00, 1'b1);
    // Re-enabled channels refresh again
    load(15'h0123, 16'h1234, 16'h5678);
    rd_chk(8'h1C, 8'h34, 1'b1);
    rd_chk(8'h19, 8'h01, 1'b1);
    close_out();
  end
endmodule : tb
